/* rtl/vtm_pkg.sv */
package vtm_pkg;
   // test selection address bits
   localparam int VTM_SEL_SELFTEST = 15;
   localparam int VTM_SEL_CORE_RST = 14;
   localparam int VTM_SEL_CLK_CLR  = 13;
   localparam int VTM_SEL_FORCE    = 12;
   localparam int VTM_ADDR_W       = 16;
   // self-test run length
   localparam int VTM_SELFTEST_CLOCKS = 4500;
   localparam int VTM_CNT_W           = 13;
   // signature analyser
   localparam int         VTM_SIG_W     = 16;
   localparam logic [15:0] VTM_SIG_SEED  = 16'hffff;
   localparam logic [15:0] VTM_SIG_POLY  = 16'h1021;
   // core pinout field widths
   localparam int VTM_CORE_MA_W = 14;
   localparam int VTM_CORE_RA_W = 5;
   localparam int VTM_DATA_W    = 8;
   // reset values
   localparam logic VTM_FORCE_RST = 1'b0;
   typedef enum logic [1:0] {VTM_IDLE, VTM_RUN, VTM_DONE} vtm_state_e;
endpackage

/* rtl/vtm_sync3.sv */
`timescale 1ns/1ps
// three-stage input synchroniser; output changes once stages two and three agree
module vtm_sync3
   import vtm_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clock_in,
   input  wire logic         rstn_in,
   input  wire logic [W-1:0] rst_val_in,
   // data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } vtm_sync_s;
   vtm_sync_s st_r;
   vtm_sync_s st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = async_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
      if (!rstn_in) begin
         st_nxt = {4{rst_val_in}};
      end
   end

   always_ff @(posedge clock_in) begin
      st_r <= st_nxt;
   end

   assign sync_out = st_r.q;
endmodule

/* rtl/vtm_test_logic.sv */
`timescale 1ns/1ps
// Contract
// - test operations start only while both cpu memory strobes are low together.
// - test condition with address 15 high exposes the core on pins and starts self-test.
// - the signature analysis runs with the core and sets pass after 4500 clocks if it matched.
// - in self-test mode the pass/fail bit drives the green video pin.
// - test condition with address 15 low and 14 high soft-resets the core.
// - test condition with address 15 low and 13 high clears clock generators and blink counter.
// - test condition with address 15 low writes address 12 into the force display bit.
// - system reset clears the force display bit.
// - in self-test core address 7..0, 8, 9, 10, 11..13 go to mem address, bank, we1, buffer, selects.
// - in self-test display, cursor, raster 0..4 and syncs go to their documented pins.
// - in self-test the core takes reset, read/write, enable, register select and data from pins.
// - in self-test the core clock is the inverted io/memory select pin.
module vtm_test_logic
   import vtm_pkg::*;
#(
   parameter int          SELFTEST_CLOCKS = VTM_SELFTEST_CLOCKS,
   parameter logic [15:0] EXPECT_SIG      = 16'h5a3c  // arbitrary golden signature
) (
   // clock and reset
   input  wire logic                     clock_in,
   input  wire logic                     rstn_in,
   // tester / cpu pins
   input  wire logic                     cpu_mem_read_strobe_n_in,
   input  wire logic                     cpu_mem_write_strobe_n_in,
   input  wire logic [VTM_ADDR_W-1:0]    sys_addr_in,
   input  wire logic                     system_reset_n_in,
   input  wire logic                     io_write_strobe_n_in,
   input  wire logic                     refresh_strobe_n_in,
   input  wire logic                     io_or_memory_select_in,
   input  wire logic [VTM_DATA_W-1:0]    cpu_data_bus_in,
   // embedded core outputs
   input  wire logic [VTM_CORE_MA_W-1:0] core_video_mem_addr_in,
   input  wire logic [VTM_CORE_RA_W-1:0] core_raster_row_addr_in,
   input  wire logic                     core_display_active_in,
   input  wire logic                     core_cursor_in,
   input  wire logic                     core_hsync_in,
   input  wire logic                     core_vsync_in,
   // normal-function pin values
   input  wire logic [7:0]               norm_video_mem_addr_in,
   input  wire logic                     norm_bank_select_in,
   input  wire logic                     norm_bank1_write_en_n_in,
   input  wire logic                     norm_bank0_write_en_n_in,
   input  wire logic                     norm_local_buffer_en_n_in,
   input  wire logic [2:0]               norm_dev_select_in,
   input  wire logic                     norm_row_strobe_n_in,
   input  wire logic                     norm_column_strobe_n_in,
   input  wire logic                     norm_red_in,
   input  wire logic                     norm_green_in,
   input  wire logic                     norm_intensity_in,
   input  wire logic                     norm_composite_sync_in,
   input  wire logic                     norm_composite_colour_in,
   input  wire logic                     norm_horiz_sync_in,
   input  wire logic                     norm_vert_sync_in,
   input  wire logic                     norm_display_active_in,
   // core control outputs
   output logic                          core_reset_n_out,
   output logic                          core_read_not_write_out,
   output logic                          core_enable_out,
   output logic                          core_reg_select_out,
   output logic                          core_select_n_out,
   output logic                          core_clock_out,
   output logic [VTM_DATA_W-1:0]         core_data_out,
   // timing side effects
   output logic                          clk_gen_clear_out,
   output logic                          display_active_out,
   output logic                          self_test_mode_out,
   // chip pins
   output logic [7:0]                    video_mem_addr_out,
   output logic                          bank_select_pin_out,
   output logic                          bank1_write_en_n_out,
   output logic                          bank0_write_en_n_out,
   output logic                          local_buffer_en_n_out,
   output logic [2:0]                    dev_select_out,
   output logic                          row_strobe_n_out,
   output logic                          column_strobe_n_out,
   output logic                          red_video_pin_out,
   output logic                          green_video_pin_out,
   output logic                          intensity_pin_out,
   output logic                          composite_sync_pin_out,
   output logic                          composite_colour_pin_out,
   output logic                          horiz_sync_pin_out,
   output logic                          vert_sync_pin_out
);
   localparam int PW = 22 + VTM_DATA_W;

   typedef struct packed {
      vtm_state_e             state;
      logic [VTM_CNT_W-1:0]   cnt;
      logic [VTM_SIG_W-1:0]   sig;
      logic                   pass;
      logic                   force_de;
      logic                   selftest;
      logic                   core_rst_n;
      logic                   clk_clr;
      logic                   core_rnw;
      logic                   core_en;
      logic                   core_rs;
      logic                   core_cs_n;
      logic                   core_clk;
      logic [VTM_DATA_W-1:0]  core_db;
      logic                   de_out;
      logic [7:0]             ma;
      logic                   bank;
      logic                   we1_n;
      logic                   we0_n;
      logic                   buf_n;
      logic [2:0]             sel;
      logic                   ras_n;
      logic                   cas_n;
      logic                   red;
      logic                   green;
      logic                   inten;
      logic                   csync;
      logic                   ccol;
      logic                   hs;
      logic                   vs;
   } vtm_state_s;

   vtm_state_s st_r;
   vtm_state_s st_nxt;

   // pin inputs resynchronised
   logic [PW-1:0] pin_raw;
   logic [PW-1:0] pin_s;
   logic [PW-1:0] pin_rst;
   assign pin_raw = {cpu_mem_read_strobe_n_in, cpu_mem_write_strobe_n_in, sys_addr_in,
                     system_reset_n_in, io_write_strobe_n_in, refresh_strobe_n_in,
                     io_or_memory_select_in, cpu_data_bus_in};
   assign pin_rst = {2'b11, 16'h0000, 4'hf, 8'h00};

   vtm_sync3 #(.W(PW)) u_sync (
      .clock_in   (clock_in),
      .rstn_in    (rstn_in),
      .rst_val_in (pin_rst),
      .async_in   (pin_raw),
      .sync_out   (pin_s)
   );

   logic                  rd_n;
   logic                  wr_n;
   logic [VTM_ADDR_W-1:0] addr;
   logic                  sys_rst_n;
   logic                  iow_n;
   logic                  rfsh_n;
   logic                  iom;
   logic [VTM_DATA_W-1:0] db;
   assign {rd_n, wr_n, addr, sys_rst_n, iow_n, rfsh_n, iom, db} = pin_s;

   logic test_cond;
   assign test_cond = !rd_n && !wr_n;

   function automatic logic [VTM_SIG_W-1:0] sig_step(input logic [VTM_SIG_W-1:0] s,
                                                     input logic [VTM_SIG_W-1:0] d);
      logic fb;
      fb       = s[VTM_SIG_W-1] ^ ^d;
      sig_step = {s[VTM_SIG_W-2:0], 1'b0} ^ (fb ? VTM_SIG_POLY : 16'h0000);
   endfunction

   logic [VTM_SIG_W-1:0] sig_data;
   assign sig_data = {core_video_mem_addr_in[7:0], core_raster_row_addr_in, core_display_active_in,
                      core_hsync_in, core_vsync_in};

   always_comb begin
      st_nxt            = st_r;
      st_nxt.selftest   = test_cond && addr[VTM_SEL_SELFTEST];
      st_nxt.core_rst_n = !(test_cond && !addr[VTM_SEL_SELFTEST]
                            && addr[VTM_SEL_CORE_RST]);
      st_nxt.clk_clr    = test_cond && !addr[VTM_SEL_SELFTEST] && addr[VTM_SEL_CLK_CLR];
      if (test_cond && !addr[VTM_SEL_SELFTEST]) begin
         st_nxt.force_de = addr[VTM_SEL_FORCE];
      end
      if (!sys_rst_n) begin
         st_nxt.force_de = VTM_FORCE_RST;
      end
      // self-test sequencing; result needs the full run
      case (st_r.state)
         VTM_IDLE: begin
            if (st_nxt.selftest) begin
               st_nxt.state = VTM_RUN;
               st_nxt.cnt   = '0;
               st_nxt.sig   = VTM_SIG_SEED;
               st_nxt.pass  = 1'b0;
            end
         end
         VTM_RUN: begin
            st_nxt.sig = sig_step(st_r.sig, sig_data);
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (!st_nxt.selftest) begin
               st_nxt.state = VTM_IDLE;
            end else if (st_r.cnt == VTM_CNT_W'(SELFTEST_CLOCKS - 1)) begin
               st_nxt.pass  = (st_nxt.sig == EXPECT_SIG);
               st_nxt.state = VTM_DONE;
            end
         end
         VTM_DONE: begin
            if (!st_nxt.selftest) begin
               st_nxt.state = VTM_IDLE;
            end
         end
         default: st_nxt.state = VTM_IDLE;
      endcase
      // core control from pins
      st_nxt.core_rnw  = iow_n;
      st_nxt.core_en   = !rfsh_n;
      st_nxt.core_rs   = addr[0];
      st_nxt.core_cs_n = !st_nxt.selftest;
      st_nxt.core_clk  = st_nxt.selftest ? !iom : 1'b0;
      st_nxt.core_db   = db;
      if (st_nxt.selftest) begin
         st_nxt.core_rst_n = sys_rst_n;
      end
      st_nxt.de_out = st_nxt.force_de || norm_display_active_in;
      // pin multiplexing
      if (st_nxt.selftest) begin
         st_nxt.ma    = core_video_mem_addr_in[7:0];
         st_nxt.bank  = core_video_mem_addr_in[8];
         st_nxt.we1_n = core_video_mem_addr_in[9];
         st_nxt.buf_n = core_video_mem_addr_in[10];
         st_nxt.sel   = core_video_mem_addr_in[13:11];
         st_nxt.csync = core_display_active_in;
         st_nxt.ccol  = core_cursor_in;
         st_nxt.ras_n = core_raster_row_addr_in[0];
         st_nxt.cas_n = core_raster_row_addr_in[1];
         st_nxt.red   = core_raster_row_addr_in[2];
         st_nxt.inten = core_raster_row_addr_in[3];
         st_nxt.we0_n = core_raster_row_addr_in[4];
         st_nxt.hs    = core_hsync_in;
         st_nxt.vs    = core_vsync_in;
         st_nxt.green = (st_r.state == VTM_DONE) && st_r.pass;
      end else begin
         st_nxt.ma    = norm_video_mem_addr_in;
         st_nxt.bank  = norm_bank_select_in;
         st_nxt.we1_n = norm_bank1_write_en_n_in;
         st_nxt.buf_n = norm_local_buffer_en_n_in;
         st_nxt.sel   = norm_dev_select_in;
         st_nxt.csync = norm_composite_sync_in;
         st_nxt.ccol  = norm_composite_colour_in;
         st_nxt.ras_n = norm_row_strobe_n_in;
         st_nxt.cas_n = norm_column_strobe_n_in;
         st_nxt.red   = norm_red_in;
         st_nxt.inten = norm_intensity_in;
         st_nxt.we0_n = norm_bank0_write_en_n_in;
         st_nxt.hs    = norm_horiz_sync_in;
         st_nxt.vs    = norm_vert_sync_in;
         st_nxt.green = norm_green_in;
      end
      if (!rstn_in) begin
         st_nxt            = '0;
         st_nxt.state      = VTM_IDLE;
         st_nxt.core_rst_n = 1'b1;
         st_nxt.core_rnw   = 1'b1;
         st_nxt.core_cs_n  = 1'b1;
         st_nxt.we1_n      = 1'b1;
         st_nxt.we0_n      = 1'b1;
         st_nxt.buf_n      = 1'b1;
         st_nxt.ras_n      = 1'b1;
         st_nxt.cas_n      = 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      st_r <= st_nxt;
   end

   assign core_reset_n_out         = st_r.core_rst_n;
   assign core_read_not_write_out  = st_r.core_rnw;
   assign core_enable_out          = st_r.core_en;
   assign core_reg_select_out      = st_r.core_rs;
   assign core_select_n_out        = st_r.core_cs_n;
   assign core_clock_out           = st_r.core_clk;
   assign core_data_out            = st_r.core_db;
   assign clk_gen_clear_out        = st_r.clk_clr;
   assign display_active_out       = st_r.de_out;
   assign self_test_mode_out       = st_r.selftest;
   assign video_mem_addr_out       = st_r.ma;
   assign bank_select_pin_out      = st_r.bank;
   assign bank1_write_en_n_out     = st_r.we1_n;
   assign bank0_write_en_n_out     = st_r.we0_n;
   assign local_buffer_en_n_out    = st_r.buf_n;
   assign dev_select_out           = st_r.sel;
   assign row_strobe_n_out         = st_r.ras_n;
   assign column_strobe_n_out      = st_r.cas_n;
   assign red_video_pin_out        = st_r.red;
   assign green_video_pin_out      = st_r.green;
   assign intensity_pin_out        = st_r.inten;
   assign composite_sync_pin_out   = st_r.csync;
   assign composite_colour_pin_out = st_r.ccol;
   assign horiz_sync_pin_out       = st_r.hs;
   assign vert_sync_pin_out        = st_r.vs;
endmodule

/* verification/vtm_tester_model.sv */
`timescale 1ns/1ps
module vtm_tester_model (
   // clock
   input  wire logic        clock_in,
   // strobes and address
   output logic             rd_n_out,
   output logic             wr_n_out,
   output logic [15:0]      addr_out,
   // core bus pins
   output logic             io_wr_n_out,
   output logic             rfsh_n_out,
   output logic             iom_out,
   output logic [7:0]       data_out
);
   int tick = 0;
   initial {rd_n_out, wr_n_out, addr_out} = {2'h3, 16'h0000};
   initial {io_wr_n_out, rfsh_n_out, iom_out, data_out} = {3'h7, 8'h00};
   // slow core bus, every tenth clock
   always @(negedge clock_in) begin
      tick <= tick + 1;
      if (tick % 10 == 9) begin
         iom_out     <= ~iom_out;
         data_out    <= data_out + 8'h5b;
         io_wr_n_out <= data_out[0];
         rfsh_n_out  <= data_out[1];
      end
   end
   task automatic apply(input logic rd_n, input logic wr_n, input logic [15:0] addr);
      @(negedge clock_in);
      rd_n_out = rd_n;
      wr_n_out = wr_n;
      addr_out = addr;
   endtask
   // full self-test run plus margin before sampling
   task automatic wait_result(input int n);
      repeat (n + 6) @(negedge clock_in);
   endtask
endmodule

/* verification/vtm_test_logic_asserts.sv */
`timescale 1ns/1ps
module vtm_test_logic_asserts
   import vtm_pkg::*;
(
   // tester pins
   input wire logic clock_in, rstn_in, system_reset_n_in, io_or_memory_select_in,
   input wire logic cpu_mem_read_strobe_n_in, cpu_mem_write_strobe_n_in,
   input wire logic io_write_strobe_n_in, refresh_strobe_n_in,
   input wire logic [VTM_ADDR_W-1:0] sys_addr_in,
   input wire logic [VTM_DATA_W-1:0] cpu_data_bus_in,
   // sources
   input wire logic [VTM_CORE_MA_W-1:0] core_video_mem_addr_in,
   input wire logic [VTM_CORE_RA_W-1:0] core_raster_row_addr_in,
   input wire logic core_display_active_in, core_cursor_in, core_hsync_in, core_vsync_in,
   input wire logic norm_display_active_in,
   // outputs
   input wire logic core_reset_n_out, core_read_not_write_out, core_enable_out,
   input wire logic core_reg_select_out, core_select_n_out, core_clock_out,
   input wire logic [VTM_DATA_W-1:0] core_data_out,
   input wire logic clk_gen_clear_out, display_active_out, self_test_mode_out,
   input wire logic [7:0] video_mem_addr_out,
   input wire logic [2:0] dev_select_out,
   input wire logic bank_select_pin_out, bank1_write_en_n_out, bank0_write_en_n_out,
   input wire logic local_buffer_en_n_out, row_strobe_n_out, column_strobe_n_out,
   input wire logic red_video_pin_out, intensity_pin_out, horiz_sync_pin_out,
   input wire logic composite_sync_pin_out, composite_colour_pin_out, vert_sync_pin_out
);
   logic [1:0] up_r;
   logic [2:0] idle_r;
   logic       warm, tst;
   assign tst  = !cpu_mem_read_strobe_n_in && !cpu_mem_write_strobe_n_in;
   assign warm = (up_r == 2'h3);
   // skip the cycles where outputs still hold reset values
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         up_r   <= 2'h0;
         idle_r <= 3'h0;
      end else begin
         up_r   <= warm ? up_r : up_r + 2'h1;
         idle_r <= tst ? 3'h0 : (idle_r == 3'h7 ? idle_r : idle_r + 3'h1);
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in || !warm);
   AST_IDLE: assert property (idle_r == 3'h7 |->
      !self_test_mode_out && !clk_gen_clear_out && core_reset_n_out) else $error("idle action");
   AST_ENTRY: assert property ((tst && sys_addr_in[15])[*7] |->
      self_test_mode_out && !core_select_n_out && !clk_gen_clear_out) else $error("no self-test");
   AST_MA_PINS: assert property (self_test_mode_out |-> {dev_select_out,
      local_buffer_en_n_out, bank1_write_en_n_out, bank_select_pin_out,
      video_mem_addr_out} == $past(core_video_mem_addr_in)) else $error("address pins");
   AST_RA_PINS: assert property (self_test_mode_out |-> {bank0_write_en_n_out,
      intensity_pin_out, red_video_pin_out, column_strobe_n_out, row_strobe_n_out,
      composite_sync_pin_out, composite_colour_pin_out, horiz_sync_pin_out,
      vert_sync_pin_out} == $past({core_raster_row_addr_in, core_display_active_in,
      core_cursor_in, core_hsync_in, core_vsync_in})) else $error("raster pins");
   AST_CORE_IN: assert property ((self_test_mode_out && $stable(cpu_data_bus_in) &&
      $stable(io_write_strobe_n_in) && $stable(refresh_strobe_n_in)
      && $stable(sys_addr_in[0]))[*7] |->
      core_data_out == cpu_data_bus_in && core_read_not_write_out == io_write_strobe_n_in
      && core_enable_out == !refresh_strobe_n_in && core_reg_select_out == sys_addr_in[0])
      else $error("core inputs");
   AST_CLK_INV: assert property ((self_test_mode_out &&
      $stable(io_or_memory_select_in))[*7] |-> core_clock_out == !io_or_memory_select_in)
      else $error("core clock");
   AST_SOFT_RST: assert property ((tst && !sys_addr_in[15] && sys_addr_in[14])[*7]
      |-> !core_reset_n_out) else $error("soft reset");
   AST_CLK_CLR: assert property ((tst && !sys_addr_in[15] && sys_addr_in[13])[*7]
      |-> clk_gen_clear_out) else $error("clock clear");
   AST_FORCE_RST: assert property ((!system_reset_n_in)[*7] |->
      display_active_out == $past(norm_display_active_in)) else $error("force bit");
   cover property ($rose(self_test_mode_out));
   cover property ($rose(clk_gen_clear_out));
   cover property ($fell(core_reset_n_out));
endmodule
bind vtm_test_logic vtm_test_logic_asserts u_vtm_test_logic_asserts (.*);

/* verification/vtm_test_logic_bench.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   tests_run++; \
   if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end
module vtm_test_logic_bench;
   import vtm_pkg::*;
   localparam int          ST_CLK = 20;
   localparam logic [31:0] FROZEN = 32'h0123_45e7;
   // crc16 reference over the frozen core outputs, one step per self-test clock
   function automatic logic [15:0] sig_ref(input int n);
      logic [15:0] s;
      logic        d;
      s = VTM_SIG_SEED;
      d = ^{FROZEN[22:21], FROZEN[19:14], FROZEN[7:0]};
      for (int i = 0; i < n; i++) begin
         s = {s[14:0], 1'b0} ^ ((s[15] ^ d) ? VTM_SIG_POLY : 16'h0000);
      end
      return s;
   endfunction
   localparam logic [15:0] GOLD_SIG = sig_ref(ST_CLK);
   int   n_mismatch = 0;
   int   tests_run  = 0;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic system_reset_n_in = 1'b1;
   logic pat_run = 1'b1;
   logic [31:0] pat = 32'h0000_0000;
   logic cpu_mem_read_strobe_n_in, cpu_mem_write_strobe_n_in, io_write_strobe_n_in;
   logic refresh_strobe_n_in, io_or_memory_select_in;
   logic [VTM_ADDR_W-1:0] sys_addr_in;
   logic [VTM_DATA_W-1:0] cpu_data_bus_in, core_data_out;
   logic [VTM_CORE_MA_W-1:0] core_video_mem_addr_in;
   logic [VTM_CORE_RA_W-1:0] core_raster_row_addr_in;
   logic core_display_active_in, core_cursor_in, core_hsync_in, core_vsync_in;
   logic [7:0] norm_video_mem_addr_in, video_mem_addr_out;
   logic [2:0] norm_dev_select_in, dev_select_out;
   logic norm_bank_select_in, norm_bank1_write_en_n_in, norm_bank0_write_en_n_in;
   logic norm_local_buffer_en_n_in, norm_row_strobe_n_in, norm_column_strobe_n_in;
   logic norm_red_in, norm_green_in, norm_intensity_in, norm_composite_sync_in;
   logic norm_composite_colour_in, norm_horiz_sync_in, norm_vert_sync_in;
   logic norm_display_active_in, core_reset_n_out, core_read_not_write_out;
   logic core_enable_out, core_reg_select_out, core_select_n_out, core_clock_out;
   logic clk_gen_clear_out, display_active_out, self_test_mode_out, bank_select_pin_out;
   logic bank1_write_en_n_out, bank0_write_en_n_out, local_buffer_en_n_out;
   logic row_strobe_n_out, column_strobe_n_out, red_video_pin_out, green_video_pin_out;
   logic intensity_pin_out, composite_sync_pin_out, composite_colour_pin_out;
   logic horiz_sync_pin_out, vert_sync_pin_out;
   always #12.5 clock_in = ~clock_in;
   always @(negedge clock_in) if (pat_run) pat <= pat + 32'h9e37_79b9;
   assign {core_vsync_in, core_hsync_in, core_cursor_in, core_display_active_in,
           core_raster_row_addr_in, core_video_mem_addr_in} = pat[22:0];
   assign {norm_video_mem_addr_in, norm_bank_select_in, norm_bank1_write_en_n_in,
           norm_bank0_write_en_n_in, norm_local_buffer_en_n_in, norm_dev_select_in,
           norm_row_strobe_n_in, norm_column_strobe_n_in, norm_red_in, norm_green_in,
           norm_intensity_in, norm_composite_sync_in, norm_composite_colour_in,
           norm_horiz_sync_in, norm_vert_sync_in, norm_display_active_in} = ~pat[31:7];
   vtm_tester_model u_vtm_tester_model (
      .clock_in(clock_in), .rd_n_out(cpu_mem_read_strobe_n_in),
      .wr_n_out(cpu_mem_write_strobe_n_in), .addr_out(sys_addr_in),
      .io_wr_n_out(io_write_strobe_n_in), .rfsh_n_out(refresh_strobe_n_in),
      .iom_out(io_or_memory_select_in), .data_out(cpu_data_bus_in));
   vtm_test_logic #(.SELFTEST_CLOCKS(ST_CLK), .EXPECT_SIG(GOLD_SIG)) u_vtm_test_logic (.*);
   task automatic settle();
      repeat (8) @(negedge clock_in);
   endtask
   task automatic t_idle();
      @(negedge clock_in) pat_run = 1'b0;
      @(negedge clock_in) pat = FROZEN;
      settle();
      `CHK(core_select_n_out, 1'b1)
      `CHK(video_mem_addr_out, ~FROZEN[31:24])
      `CHK(green_video_pin_out, ~FROZEN[13])
      for (int i = 0; i < 2; i++) begin
         u_vtm_tester_model.apply(i[0], !i[0], 16'hf000);
         settle();
         `CHK({self_test_mode_out, clk_gen_clear_out, core_reset_n_out}, 3'h1)
         `CHK(display_active_out, ~FROZEN[7])
      end
      $display("test idle done");
   endtask
   task automatic t_selftest();
      logic [13:0] ma;
      logic [8:0]  ra;
      u_vtm_tester_model.apply(1'b0, 1'b0, 16'hf001);
      settle();
      ma = {dev_select_out, local_buffer_en_n_out, bank1_write_en_n_out,
            bank_select_pin_out, video_mem_addr_out};
      ra = {vert_sync_pin_out, horiz_sync_pin_out, composite_colour_pin_out,
            composite_sync_pin_out, bank0_write_en_n_out, intensity_pin_out,
            red_video_pin_out, column_strobe_n_out, row_strobe_n_out};
      `CHK({self_test_mode_out, clk_gen_clear_out, core_reset_n_out}, 3'h5)
      `CHK({core_select_n_out, core_reg_select_out}, 2'h1)
      `CHK(green_video_pin_out, 1'b0)
      `CHK(ma, FROZEN[13:0])
      `CHK(ra, FROZEN[22:14])
      system_reset_n_in = 1'b0;
      settle();
      `CHK(core_reset_n_out, 1'b0)
      system_reset_n_in = 1'b1;
      u_vtm_tester_model.wait_result(ST_CLK);
      `CHK(green_video_pin_out, 1'b1)
      u_vtm_tester_model.apply(1'b1, 1'b1, 16'h0000);
      settle();
      `CHK({self_test_mode_out, green_video_pin_out}, {1'b0, ~FROZEN[13]})
      $display("test self-test done");
   endtask
   task automatic t_modes();
      logic [15:0] tbl [5] = '{16'h4000, 16'h2000, 16'h1000, 16'h0000, 16'h7000};
      foreach (tbl[k]) begin
         u_vtm_tester_model.apply(1'b0, 1'b0, tbl[k]);
         settle();
         `CHK(core_reset_n_out, !tbl[k][14])
         `CHK(clk_gen_clear_out, tbl[k][13])
         `CHK(display_active_out, tbl[k][12])
      end
      u_vtm_tester_model.apply(1'b1, 1'b1, 16'h0000);
      settle();
      `CHK({display_active_out, clk_gen_clear_out}, 2'h2)
      u_vtm_tester_model.apply(1'b0, 1'b1, 16'h0000);
      settle();
      `CHK(display_active_out, 1'b1)
      system_reset_n_in = 1'b0;
      settle();
      `CHK(display_active_out, 1'b0)
      system_reset_n_in = 1'b1;
      $display("test modes done");
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock_in);
      @(negedge clock_in) rstn_in = 1'b1;
      t_idle();
      t_selftest();
      t_modes();
      final_report();
   end
   initial begin
      repeat (3000) @(posedge clock_in);
      n_mismatch++;
      final_report();
   end
endmodule
